// [adhc_pkg.sv]
package adhc_pkg;
    // ----------------------------------------------------------------
    // values and timing
    // ----------------------------------------------------------------
    typedef logic signed [15:0] adhc_val_t; // tenths of a unit
    localparam int CLK_HZ = 40_000_000;
    localparam int CYC_STEP_MS = 100; // cycle time counts in 0.1 s
    localparam int CYC_STEP_CLKS = CLK_HZ / 1000 * CYC_STEP_MS;
    localparam int DWELL_STEP_S = 6; // dwell time counts in 0.1 min
    localparam int DWELL_STEP_CLKS = CLK_HZ * DWELL_STEP_S;
    localparam logic signed [17:0] FULL_SCALE = 18'sh003e8; // 100.0 %
    localparam logic signed [15:0] DB_LIMIT = 16'sh0168; // 36.0 %
    localparam logic [7:0] CPB_MIN = 8'h01;
    localparam logic [7:0] CPB_RESET = 8'h64; // 100 %
    localparam logic [3:0] EVENT_INPUT_FUNCTION_CLEAR_LATCH = 4'h1;
    // ----------------------------------------------------------------
    // register map (byte offsets)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BAND = 8'h04;
    localparam logic [7:0] OFS_HC = 8'h08;
    localparam logic [7:0] OFS_CYC = 8'h0c;
    localparam logic [7:0] OFS_DWELL = 8'h10;
    localparam logic [7:0] OFS_ALM_BASE = 8'h14;
    localparam logic [7:0] OFS_ALM_STEP = 8'h0c; // cfg, level, deviation
    localparam logic [7:0] OFS_STATUS = 8'h2c;
    localparam int CTRL_DIRECT = 0;
    localparam int CTRL_O2FN = 1; // two bits
    localparam int CTRL_O1LIN = 3;
    localparam int CTRL_O2LIN = 4;
    localparam int CTRL_COMBO = 5; // three bits
    localparam int CTRL_EVENT_INPUT_FUNCTION = 8; // four bits
    // ----------------------------------------------------------------
    // enumerations and carriers
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        FN_PV1_HI = 4'h0, FN_PV1_LO = 4'h1, FN_PV2_HI = 4'h2, FN_PV2_LO = 4'h3,
        FN_EITHER_HI = 4'h4, FN_EITHER_LO = 4'h5, FN_DIFF_HI = 4'h6, FN_DIFF_LO = 4'h7,
        FN_DEV_HI = 4'h8, FN_DEV_LO = 4'h9, FN_DWELL = 4'ha, FN_NONE = 4'hf
    } adhc_fn_e;
    typedef enum logic [1:0] {
        MD_NORMAL = 2'h0, MD_LATCH = 2'h1, MD_HOLD = 2'h2, MD_LATCH_HOLD = 2'h3
    } adhc_mode_e;
    typedef enum logic [1:0] {
        O2_NONE = 2'h0, O2_COOL = 2'h1, O2_ALARM2 = 2'h2
    } adhc_o2_e;
    typedef struct packed {
        adhc_mode_e mode;
        adhc_fn_e fn;
    } adhc_alm_cfg_s;
    localparam adhc_alm_cfg_s ALM_CFG_RESET = '{mode: MD_NORMAL, fn: FN_NONE};
endpackage : adhc_pkg

// [adhc_relay_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// field relays on the alarm outputs
// ----------------------------------------------------------------
module adhc_relay_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [1:0] coil,
    output logic [1:0] contact_r
);
    // contacts follow the coils one clock late, as a slow armature would
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            contact_r <= 2'h0;
        end else begin
            contact_r <= coil;
        end
    end
endmodule : adhc_relay_model
`default_nettype wire

// [adhc_top.sv]
// Notes on behaviour
// - direct action drives output 1 inversely to reverse (heat) action in every form; here proportional output 1 in heat/cool mode ignores direct.
// - six heat/cool combinations; output 1, output 2 or an alarm drives each side; here heat is always output 1 and cool output 2.
// - output 1 hysteresis acts only when primary band is zero (on-off).
// - cooling band is a percentage of heating band, 1 to 255.
// - tuning never alters the stored cooling band percentage.
// - signed dead band, limited to -36.0 .. +36.0 percent of band.
// - negative dead band: both heat and cool active across the overlap.
// - positive dead band: neither heat nor cool active inside the dead zone.
// - linear outputs ignore cycle time; it only paces switching outputs.
// - both alarms as dwell timer is a configuration error.
// - dwell time counts tenths of a minute, 0 to 6553.5.
// - dwell count starts from zero when process first reaches set point.
// - dwell relay holds its state while counting, changes only on time out.
// - eight process alarm functions: high/low on pv1, pv2, either, difference.
// - either-value alarm trips on pv1 or pv2 crossing the level.
// - difference alarm compares pv1 minus pv2 with the absolute level.
// - process thresholds are alarm level plus and minus half hysteresis.
// - normal mode: output energised exactly while the alarm condition holds.
// - latching mode: output stays energised after the condition clears.
// - latch released only by power loss or the clear-latch event input.
// - holding mode: no alarm until process first reaches set point.
// - latch/hold mode combines holding suppression and latching.
// - deviation value is signed per channel, above or below set point.
// - deviation thresholds track set point: set point plus deviation, half hysteresis.
// - alarm 2 repeats alarm 1 behaviour with its own settings.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module adhc_top import adhc_pkg::*; #(
    parameter int CYC_TICK_CLKS = CYC_STEP_CLKS,
    parameter int DWELL_TICK_CLKS = DWELL_STEP_CLKS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [15:0] primary_process_value,
    input wire logic signed [15:0] secondary_process_value,
    input wire logic signed [15:0] primary_setpoint,
    input wire logic signed [15:0] pid_demand,
    input wire logic event_input,
    output logic [9:0] output1_action_select_level,
    output logic output1_action_select_pin,
    output logic [9:0] output2_function_select_level,
    output logic output2_function_select_pin,
    output logic [1:0] alarm_out,
    output logic cfg_error
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // clamp a signed drive figure into 0 .. full scale
    function automatic logic [9:0] clamp_fs(input logic signed [17:0] v);
        if (v <= 18'sh0)
            return 10'h0;
        if (v >= FULL_SCALE)
            return FULL_SCALE[9:0];
        return v[9:0];
    endfunction : clamp_fs

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [11:0] ctrl_r;
    logic [15:0] pb1_r;
    logic [15:0] o1_hyst_r;
    logic [7:0] cpb_r;
    adhc_val_t db_r;
    logic [15:0] cyc_r [2];
    logic [15:0] dwell_time_r;
    adhc_alm_cfg_s al_cfg_r [2];
    adhc_val_t al_sp_r [2];
    logic [15:0] al_hy_r [2];
    adhc_val_t al_dv_r [2];
    logic reached_r;
    logic [15:0] dwell_cnt_r;
    logic onoff_r;
    logic [1:0] cond_r;
    logic [1:0] alarm_r;
    logic [31:0] status_w;
    logic wr_en;
    logic hit;
    logic signed [15:0] wr_db;
    logic [1:0] alm_sel_hit;
    logic [1:0] alm_part;

    assign pready = 1'b1; // single-cycle access phase, never stretched
    assign wr_en = psel && penable && pwrite;
    assign wr_db = pwdata[31:16];

    // decode which alarm channel and which word of it an address picks
    always_comb begin
        alm_sel_hit = 2'b00;
        alm_part = 2'h0;
        for (int i = 0; i < 2; i++) begin
            for (int k = 0; k < 3; k++) begin
                if (paddr == 8'(OFS_ALM_BASE + OFS_ALM_STEP * i + 4 * k)) begin
                    alm_sel_hit[i] = 1'b1;
                    alm_part = 2'(k);
                end
            end
        end
    end

    assign hit = (paddr == OFS_CTRL) || (paddr == OFS_BAND) || (paddr == OFS_HC)
        || (paddr == OFS_CYC) || (paddr == OFS_DWELL) || (paddr == OFS_STATUS)
        || (|alm_sel_hit);
    assign pslverr = psel && penable && !hit;

    // control words; cooling band and dead band are clamped on write
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_r <= {4'h0, 3'h0, 1'b0, 1'b0, O2_NONE, 1'b0};
            pb1_r <= 16'h0;
            o1_hyst_r <= 16'h0;
            cpb_r <= CPB_RESET;
            db_r <= 16'sh0;
            cyc_r <= '{16'h0, 16'h0};
            dwell_time_r <= 16'h0;
        end else if (wr_en) begin
            unique case (paddr)
                OFS_CTRL: ctrl_r <= pwdata[11:0];
                OFS_BAND: begin
                    pb1_r <= pwdata[15:0];
                    o1_hyst_r <= pwdata[31:16];
                end
                OFS_HC: begin
                    // only software writes reach this field; tuning has no path
                    cpb_r <= (pwdata[7:0] < CPB_MIN) ? CPB_MIN : pwdata[7:0];
                    if (wr_db > DB_LIMIT)
                        db_r <= DB_LIMIT;
                    else if (wr_db < -DB_LIMIT)
                        db_r <= -DB_LIMIT;
                    else
                        db_r <= wr_db;
                end
                OFS_CYC: cyc_r <= '{pwdata[15:0], pwdata[31:16]};
                OFS_DWELL: dwell_time_r <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // alarm settings: one set per channel
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            al_cfg_r <= '{ALM_CFG_RESET, ALM_CFG_RESET};
            al_sp_r <= '{16'sh0, 16'sh0};
            al_hy_r <= '{16'h0, 16'h0};
            al_dv_r <= '{16'sh0, 16'sh0};
        end else if (wr_en) begin
            for (int i = 0; i < 2; i++) begin
                if (alm_sel_hit[i]) begin
                    unique case (alm_part)
                        2'h0: al_cfg_r[i] <= pwdata[5:0];
                        2'h1: begin
                            al_sp_r[i] <= pwdata[15:0];
                            al_hy_r[i] <= pwdata[31:16];
                        end
                        default: al_dv_r[i] <= pwdata[15:0];
                    endcase
                end
            end
        end
    end

    assign status_w = {dwell_cnt_r, 9'h0, cfg_error, reached_r, alarm_r, output2_function_select_pin, output1_action_select_pin, onoff_r};

    // read data comes straight from the register bank
    always_comb begin
        prdata = 32'h0;
        unique case (paddr)
            OFS_CTRL: prdata = {20'h0, ctrl_r};
            OFS_BAND: prdata = {o1_hyst_r, pb1_r};
            OFS_HC: prdata = {db_r, 8'h0, cpb_r};
            OFS_CYC: prdata = {cyc_r[1], cyc_r[0]};
            OFS_DWELL: prdata = {16'h0, dwell_time_r};
            OFS_STATUS: prdata = status_w;
            default: begin
                for (int i = 0; i < 2; i++) begin
                    if (alm_sel_hit[i]) begin
                        if (alm_part == 2'h0)
                            prdata = {26'h0, al_cfg_r[i]};
                        else if (alm_part == 2'h1)
                            prdata = {al_hy_r[i], al_sp_r[i]};
                        else
                            prdata = {{16{al_dv_r[i][15]}}, al_dv_r[i]};
                    end
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // control outputs
    // ----------------------------------------------------------------
    logic direct;
    logic heat_cool;
    logic signed [17:0] err;
    logic signed [17:0] act_err;
    logic signed [17:0] o1_half;
    logic signed [17:0] heat_raw;
    logic signed [17:0] cool_raw;
    logic signed [25:0] cool_scaled;
    logic [9:0] output1_action_select_nxt;
    logic [9:0] output2_function_select_nxt;
    logic [1:0] lin;

    assign direct = ctrl_r[CTRL_DIRECT];
    assign heat_cool = ctrl_r[CTRL_O2FN +: 2] == O2_COOL;
    assign lin = {ctrl_r[CTRL_O2LIN], ctrl_r[CTRL_O1LIN]};
    assign err = 18'(primary_setpoint) - 18'(primary_process_value);
    assign act_err = direct ? -err : err; // direct action sees the error turned round
    assign o1_half = 18'({1'b0, o1_hyst_r[15:1]});

    // on-off state with a hysteresis window around the set point
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            onoff_r <= 1'b0;
        else if (act_err > o1_half)
            onoff_r <= 1'b1;
        else if (act_err < -o1_half)
            onoff_r <= 1'b0;
    end

    // dead band is split evenly so that zero demand sits mid-band
    always_comb begin
        heat_raw = direct ? -18'(pid_demand) : 18'(pid_demand);
        cool_raw = 18'sh0;
        cool_scaled = 26'sh0;
        if (heat_cool) begin
            heat_raw = 18'(pid_demand) - 18'(db_r >>> 1);
            cool_raw = -18'(pid_demand) - 18'(db_r >>> 1);
            cool_scaled = 26'(cool_raw * 26'sd100 / 26'($signed({1'b0, cpb_r})));
        end
        if (pb1_r == 16'h0)
            output1_action_select_nxt = onoff_r ? FULL_SCALE[9:0] : 10'h0;
        else
            output1_action_select_nxt = clamp_fs(heat_raw);
        if (cool_scaled > 26'(FULL_SCALE))
            output2_function_select_nxt = FULL_SCALE[9:0];
        else
            output2_function_select_nxt = clamp_fs(cool_scaled[17:0]);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            output1_action_select_level <= 10'h0;
            output2_function_select_level <= 10'h0;
        end else begin
            output1_action_select_level <= output1_action_select_nxt;
            output2_function_select_level <= heat_cool ? output2_function_select_nxt : 10'h0;
        end
    end

    // ----------------------------------------------------------------
    // time-proportioned switching
    // ----------------------------------------------------------------
    logic [31:0] cyc_div_r;
    logic cyc_tick;
    logic [1:0] pin_r;

    always_ff @(posedge core_clk) begin
        if (!rst_n || cyc_tick)
            cyc_div_r <= 32'h0;
        else
            cyc_div_r <= cyc_div_r + 32'h1;
    end
    assign cyc_tick = cyc_div_r == 32'(CYC_TICK_CLKS - 1);

    for (genvar g = 0; g < 2; g++) begin : g_pwm
        logic [15:0] pos_r;
        logic [9:0] lvl;
        logic [25:0] on_len;
        assign lvl = (g == 0) ? output1_action_select_level : output2_function_select_level;
        assign on_len = 26'(lvl) * 26'(cyc_r[g]);
        always_ff @(posedge core_clk) begin
            if (!rst_n)
                pos_r <= 16'h0;
            else if (cyc_tick)
                pos_r <= (pos_r + 16'h1 >= cyc_r[g]) ? 16'h0 : pos_r + 16'h1;
        end
        // a linear output carries the level only; its pin stays low
        always_ff @(posedge core_clk) begin
            if (!rst_n)
                pin_r[g] <= 1'b0;
            else
                pin_r[g] <= !lin[g] && (on_len > 26'(pos_r) * 26'(FULL_SCALE));
        end
    end
    assign output1_action_select_pin = pin_r[0];
    assign output2_function_select_pin = pin_r[1];

    // ----------------------------------------------------------------
    // set point reached and dwell timer
    // ----------------------------------------------------------------
    logic init_r;
    logic below_r;
    logic [31:0] dwell_div_r;
    logic dwell_done;

    // the side of the set point is caught once after reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            init_r <= 1'b0;
            below_r <= 1'b0;
            reached_r <= 1'b0;
        end else begin
            init_r <= 1'b1;
            if (!init_r)
                below_r <= err > 18'sh0;
            else if (below_r ? err <= 18'sh0 : err >= 18'sh0)
                reached_r <= 1'b1;
        end
    end

    assign cfg_error = (al_cfg_r[0].fn == FN_DWELL) && (al_cfg_r[1].fn == FN_DWELL);
    assign dwell_done = reached_r && (dwell_cnt_r >= dwell_time_r);

    // counting begins from zero at the first reach of the set point
    always_ff @(posedge core_clk) begin
        if (!rst_n || !reached_r) begin
            dwell_div_r <= 32'h0;
            dwell_cnt_r <= 16'h0;
        end else if (!dwell_done) begin
            if (dwell_div_r == 32'(DWELL_TICK_CLKS - 1)) begin
                dwell_div_r <= 32'h0;
                dwell_cnt_r <= dwell_cnt_r + 16'h1;
            end else begin
                dwell_div_r <= dwell_div_r + 32'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // alarm channels
    // ----------------------------------------------------------------
    logic clr_latch;
    logic [1:0] cond_nxt;
    logic [1:0] alarm_nxt;
    assign clr_latch = event_input && ctrl_r[CTRL_EVENT_INPUT_FUNCTION +: 4] == EVENT_INPUT_FUNCTION_CLEAR_LATCH;

    for (genvar c = 0; c < 2; c++) begin : g_alm
        adhc_alm_cfg_s cfg;
        logic signed [17:0] mon;
        logic signed [17:0] lvl;
        logic signed [17:0] half;
        logic is_high;
        logic latching;
        logic holding;
        logic act;
        assign cfg = al_cfg_r[c];
        assign half = 18'({1'b0, al_hy_r[c][15:1]});
        assign is_high = !cfg.fn[0];
        assign latching = cfg.mode == MD_LATCH || cfg.mode == MD_LATCH_HOLD;
        assign holding = cfg.mode == MD_HOLD || cfg.mode == MD_LATCH_HOLD;

        // pick the watched value and its level
        always_comb begin
            lvl = 18'(al_sp_r[c]);
            unique case (cfg.fn)
                FN_PV1_HI, FN_PV1_LO: mon = 18'(primary_process_value);
                FN_PV2_HI, FN_PV2_LO: mon = 18'(secondary_process_value);
                FN_EITHER_HI: mon = (primary_process_value > secondary_process_value) ?
                    18'(primary_process_value) : 18'(secondary_process_value);
                FN_EITHER_LO: mon = (primary_process_value < secondary_process_value) ?
                    18'(primary_process_value) : 18'(secondary_process_value);
                FN_DIFF_HI, FN_DIFF_LO:
                    mon = 18'(primary_process_value) - 18'(secondary_process_value);
                FN_DEV_HI, FN_DEV_LO: begin
                    mon = 18'(primary_process_value);
                    lvl = 18'(primary_setpoint) + 18'(al_dv_r[c]);
                end
                default: mon = lvl;
            endcase
        end

        // hysteresis window; inside it the condition keeps its last value
        always_comb begin
            cond_nxt[c] = cond_r[c];
            if (cfg.fn > FN_DEV_LO)
                cond_nxt[c] = 1'b0;
            else if (mon > lvl + half)
                cond_nxt[c] = is_high;
            else if (mon < lvl - half)
                cond_nxt[c] = !is_high;
        end

        assign act = cond_nxt[c] && (!holding || reached_r);

        // a latch is dropped by the event only while the cause has gone
        always_comb begin
            if (cfg.fn == FN_DWELL)
                alarm_nxt[c] = !cfg_error && dwell_done;
            else if (latching)
                alarm_nxt[c] = act || (alarm_r[c] && !clr_latch);
            else
                alarm_nxt[c] = act;
        end

        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                cond_r[c] <= 1'b0;
                alarm_r[c] <= 1'b0;
            end else begin
                cond_r[c] <= cond_nxt[c];
                alarm_r[c] <= alarm_nxt[c];
            end
        end

        a_normal_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
            cfg.mode == MD_NORMAL && cfg.fn <= FN_DEV_LO |=> alarm_r[c] == $past(cond_nxt[c]))
            else $error("normal alarm does not follow its condition");
        a_latch_keeps: assert property (@(posedge core_clk) disable iff (!rst_n)
            latching && cfg.fn <= FN_DEV_LO && alarm_r[c] && !clr_latch && $stable(cfg) |=> alarm_r[c])
            else $error("latched alarm dropped without clear");
        a_hold_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
            holding && cfg.fn <= FN_DEV_LO && !reached_r ##1 $stable(cfg) |-> !alarm_r[c])
            else $error("holding alarm fired before set point reached");
        a_dwell_relay: assert property (@(posedge core_clk) disable iff (!rst_n)
            cfg.fn == FN_DWELL && !cfg_error && !dwell_done ##1 $stable(cfg) |-> !alarm_r[c])
            else $error("dwell relay changed before time out");
    end
    assign alarm_out = alarm_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_cfg_flagged: assert property (@(posedge core_clk) disable iff (!rst_n)
        al_cfg_r[0].fn == FN_DWELL && al_cfg_r[1].fn == FN_DWELL |-> cfg_error ##1 alarm_r == 2'b00)
        else $error("double dwell timer not flagged");
    a_cpb_range: assert property (@(posedge core_clk) disable iff (!rst_n)
        cpb_r >= CPB_MIN)
        else $error("cooling band below one percent");
    a_db_range: assert property (@(posedge core_clk) disable iff (!rst_n)
        db_r <= DB_LIMIT && db_r >= -DB_LIMIT)
        else $error("dead band outside limit");
    a_onoff_full: assert property (@(posedge core_clk) disable iff (!rst_n)
        pb1_r == 16'h0 && $stable(pb1_r) |=> output1_action_select_level == 10'h0 || output1_action_select_level == FULL_SCALE[9:0])
        else $error("on-off output not full on or off");
    a_linear_pin: assert property (@(posedge core_clk) disable iff (!rst_n)
        lin[0] |=> !output1_action_select_pin)
        else $error("linear output pin toggled");
    a_dwell_count: assert property (@(posedge core_clk) disable iff (!rst_n)
        !reached_r |=> dwell_cnt_r == 16'h0)
        else $error("dwell counted before set point reached");
    c_dwell_done: cover property (@(posedge core_clk) disable iff (!rst_n) dwell_done);
    c_latch_clear: cover property (@(posedge core_clk) disable iff (!rst_n)
        alarm_r[0] && clr_latch ##1 !alarm_r[0]);
    c_overlap: cover property (@(posedge core_clk) disable iff (!rst_n)
        heat_cool && output1_action_select_level != 10'h0 && output2_function_select_level != 10'h0);
endmodule : adhc_top
`default_nettype wire

// [tb_alarm_dwell_heat_cool_logic.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_alarm_dwell_heat_cool_logic import adhc_pkg::*;;
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, event_input = 0, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, output1_action_select_pin, output2_function_select_pin, cfg_error;
    logic signed [15:0] pv1 = 16'sh0, pv2 = 16'sh0, sp = 16'sh0, dem = 16'sh0;
    logic [9:0] l1, l2;
    logic [1:0] alarm_out, contact;
    int error_cnt = 0, n_compared = 0;
    typedef struct packed {logic [3:0] fn; logic [15:0] p1; logic [15:0] p2; logic ex;} adhc_row_s;
    // one row per process and deviation alarm function: pv1 and pv2 sit well outside the hysteresis window
    adhc_row_s rows[10] = '{'{4'h0, 16'h0834, 16'h0, 1'b1}, '{4'h1, 16'h0834, 16'h0, 1'b0},
        '{4'h2, 16'h0, 16'h0834, 1'b1}, '{4'h3, 16'h0, 16'h0834, 1'b0}, '{4'h4, 16'h0, 16'h0834, 1'b1},
        '{4'h5, 16'h0834, 16'h0, 1'b1}, '{4'h6, 16'h0834, 16'h0, 1'b1}, '{4'h7, 16'h0834, 16'h0, 1'b0},
        '{4'h8, 16'h0834, 16'h0, 1'b1}, '{4'h9, 16'h0834, 16'h0, 1'b0}};
    always #12.5 core_clk = ~core_clk;
    adhc_top #(.CYC_TICK_CLKS(10), .DWELL_TICK_CLKS(20)) DUT (.core_clk(core_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .primary_process_value(pv1), .secondary_process_value(pv2),
        .primary_setpoint(sp), .pid_demand(dem), .event_input(event_input), .output1_action_select_level(l1),
        .output1_action_select_pin(output1_action_select_pin), .output2_function_select_level(l2), .output2_function_select_pin(output2_function_select_pin), .alarm_out(alarm_out), .cfg_error(cfg_error));
    adhc_relay_model relays (.core_clk(core_clk), .rst_n(rst_n), .coil(alarm_out), .contact_r(contact));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    // request held until pready is seen high at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task cfg(input logic [3:0] fn, input logic [1:0] md);
        apb(1, OFS_ALM_BASE, {26'h0, md, fn});
        apb(1, OFS_ALM_BASE + OFS_ALM_STEP, {26'h0, md, fn});
    endtask : cfg
    task step(input logic [15:0] p, input logic ex);
        pv1 <= p;
        repeat (3) @(posedge core_clk);
        chk(alarm_out, {2{ex}});
        chk(contact, {2{ex}});
    endtask : step
    task close_out;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // watchdog: the whole sequence needs well under 2000 clocks
    initial begin
        #100000;
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1;
        apb(0, OFS_HC, 32'h0);
        chk(q, 32'h64);
        apb(1, OFS_HC, 32'h03e8_0000);
        apb(0, OFS_HC, 32'h0);
        chk(q, 32'h0168_0001);
        apb(0, 8'h30, 32'h0);
        chk(e, 1'b1);
        sp <= 16'sh03e8;
        apb(1, 8'h18, 32'h0064_07d0);
        apb(1, 8'h24, 32'h0064_07d0);
        apb(1, 8'h1c, 32'h64);
        apb(1, 8'h28, 32'h64);
        foreach (rows[i]) begin
            cfg(rows[i].fn, MD_NORMAL);
            pv2 <= rows[i].p2;
            step(rows[i].p1, rows[i].ex);
        end
        // hysteresis window 1950..2050 around the 2000 level
        cfg(4'h0, MD_NORMAL);
        step(16'h0, 0);
        step(16'h07f8, 0);
        step(16'h080c, 1);
        step(16'h07a8, 1);
        step(16'h0794, 0);
        apb(1, OFS_CTRL, 32'h100);
        cfg(4'h0, MD_LATCH);
        step(16'h0834, 1);
        step(16'h0, 1);
        event_input <= 1;
        step(16'h0, 0);
        event_input <= 0;
        cfg(FN_DWELL, MD_NORMAL);
        @(posedge core_clk);
        chk(cfg_error, 1'b1);
        // on-off output 1 over a four-step cycle, then linear, then direct action
        apb(1, OFS_CYC, 32'h0004_0004);
        step(16'h0, 0);
        chk(l1, 10'h3e8);
        chk(output1_action_select_pin, 1'b1);
        apb(1, OFS_CTRL, 32'h108);
        step(16'h0, 0);
        chk(l1, 10'h3e8);
        chk(output1_action_select_pin, 1'b0);
        apb(1, OFS_CTRL, 32'h101);
        step(16'h0, 0);
        chk(l1, 10'h0);
        // heat-cool: a positive dead band swallows a small demand, a negative one overlaps
        apb(1, OFS_BAND, 32'h64);
        apb(1, OFS_CTRL, 32'h102);
        dem <= 16'sh0064;
        step(16'h0, 0);
        chk({l1, l2}, 20'h0);
        chk(output2_function_select_pin, 1'b0);
        apb(1, OFS_HC, 32'hff60_0032);
        dem <= 16'sh0;
        step(16'h0, 0);
        chk(l1, 10'h050);
        chk(l2, 10'h0a0);
        // second reset below set point: holding suppresses, the dwell timer waits
        rst_n <= 0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1;
        apb(1, 8'h18, 32'h0064_07d0);
        apb(1, OFS_ALM_BASE, 32'h31);
        apb(1, 8'h20, 32'ha);
        apb(1, OFS_DWELL, 32'h2);
        step(16'h0, 0);
        pv1 <= 16'h03e8;
        repeat (30) @(posedge core_clk);
        chk(alarm_out, 2'b01);
        pv1 <= 16'h0834;
        repeat (20) @(posedge core_clk);
        chk(alarm_out, 2'b11);
        close_out();
    end
endmodule : tb_alarm_dwell_heat_cool_logic
`default_nettype wire
